// ===== hdl/bmdiag_pkg.sv
// Purpose: Shared constants and types for the battery monitor diagnostic block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   Printed offsets are register indices; byte address is four times
package bmdiag_pkg;

	localparam logic [7:0] IDX_BAL_LOW_THR  = 8'h4c;
	localparam logic [7:0] IDX_BAL_HIGH_THR = 8'h4d;
	localparam logic [7:0] IDX_DIAGNOSTIC_RESULT_RESULT  = 8'h50;
	localparam logic [7:0] IDX_DIAGNOSTIC_RESULT_CONFIG  = 8'h51;
	localparam logic [7:0] IDX_CELL_TST_EN  = 8'h52;
	localparam logic [7:0] IDX_ALU_ODD_1    = 8'h57;
	localparam logic [7:0] IDX_ALU_ODD_2    = 8'h58;
	localparam logic [7:0] IDX_ALU_EVEN_1   = 8'h59;
	localparam logic [7:0] IDX_ALU_EVEN_2   = 8'h5a;
	localparam logic [7:0] IDX_CAL_FIRST    = 8'hc0;
	localparam logic [7:0] IDX_CAL_LAST     = 8'hca;
	localparam logic [7:0] IDX_CAL_EXTRA    = 8'hcf;
	localparam logic [7:0] IDX_CONTROL      = 8'h60;
	localparam logic [7:0] IDX_STATUS       = 8'h61;

	localparam logic [15:0] MASK_THR14      = 16'hfffc;
	localparam logic [15:0] MASK_DIAGNOSTIC_RESULT_CFG   = 16'hfbdf;
	localparam logic [15:0] MASK_CELL_EN    = 16'h1fff;
	localparam logic [15:0] MASK_ALU_WORD   = 16'h0fff;
	localparam logic [15:0] MASK_CONTROL    = 16'h0003;
	localparam logic [15:0] RST_ZERO        = 16'h0000;
	localparam logic [15:0] RST_ALU_ODD     = 16'h0000;
	localparam logic [15:0] CAL_DEFAULT     = 16'h0000;

	localparam int CFG_LEVEL_LSB  = 12;
	localparam int CFG_DIR_BIT    = 11;
	localparam int CFG_AUX_LSB    = 8;
	localparam int CFG_BUS_BIT    = 7;
	localparam int CFG_PAIR_BIT   = 6;
	localparam int CFG_MUXEN_BIT  = 4;
	localparam int CFG_ALT_BIT    = 3;
	localparam int CTL_ALU_BIT    = 0;
	localparam int CTL_OVS_BIT    = 1;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		BMDG_SEL_NONE   = 3'b000,
		BMDG_SEL_ALTERNATE_REFERENCE = 3'b001,
		BMDG_SEL_SUPPLY = 3'b010,
		BMDG_SEL_OFFSET = 3'b011,
		BMDG_SEL_ZERO   = 3'b100,
		BMDG_SEL_FULL   = 3'b101,
		BMDG_SEL_DIE    = 3'b110,
		BMDG_SEL_SPARE  = 3'b111
	} bmdg_sel_t;

	typedef enum logic [3:0] {
		BMDG_CONV_ODD1  = 4'b0001,
		BMDG_CONV_ODD2  = 4'b0010,
		BMDG_CONV_EVEN1 = 4'b0100,
		BMDG_CONV_EVEN2 = 4'b1000
	} bmdg_conv_t;

	typedef struct packed {
		logic [3:0]  level;
		logic        source;
		logic [1:0]  aux_en;
		logic [12:0] cell_en;
		logic        mux_en;
		logic        mux_even;
		logic        mux_odd;
		logic        alt_input;
		bmdg_sel_t   selector;
	} bmdg_analog_t;

	typedef struct packed {
		logic        valid;
		logic [13:0] value;
		logic        bal_test;
	} bmdg_result_t;

endpackage

// ===== hdl/bmdiag_top.sv
// Purpose: Diagnostic configuration, thresholds, results and ALU test words
// Assumes: Single clock aclk, synchronous active-low reset, AXI4-Lite slave
// Notes:   Analog controls leave as registered levels; converter feeds a result stream
//
// How it works
// - Balancing-test result below low threshold raises alert
// - Balancing-test result above high threshold raises alert
// - Result register: 14-bit result high, low two zero
// - Four-bit field sets test current magnitude
// - Bus select routes mux current even/odd
// - Pair mode drives both mux test outputs
// - Mux diagnostic enable turns mux current on
// - Alternate select uses alternate mux inputs
// - Thirteen per-cell test current enables
// - Odd sample first conversion uses word one
// - Odd sample second conversion uses word two
// - Even sample first conversion uses word three
// - Even sample second conversion uses word four
// - Calibration words read trim, ignore writes
// - Reserved bits always read zero
`timescale 1ns/10ps
module bmdiag_top
	import bmdiag_pkg::*;
#(
	parameter logic [15:0] CAL_TRIM = CAL_DEFAULT
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [31:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [31:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire bmdg_result_t conv_result,
	input  wire logic         conv_start,
	input  wire logic         conv_sample_end,
	input  wire logic [11:0]  adc_data,
	output bmdg_analog_t      analog_ctl,
	output logic [11:0]       alu_data,
	output logic              bal_alert
);

	logic [15:0]  low_thr_q, low_thr_d;
	logic [15:0]  high_thr_q, high_thr_d;
	logic [15:0]  diagnostic_result_q, diagnostic_result_d;
	logic [15:0]  cfg_q, cfg_d;
	logic [15:0]  cell_en_q, cell_en_d;
	logic [15:0]  alu_word_q [4];
	logic [15:0]  alu_word_d [4];
	logic [15:0]  ctl_q, ctl_d;
	logic         alert_q, alert_d;
	bmdg_conv_t   conv_q, conv_d;
	logic [11:0]  alu_q, alu_d;
	bmdg_analog_t ana_q, ana_d;

	logic         aw_held_q, aw_held_d;
	logic         w_held_q, w_held_d;
	logic [7:0]   aw_idx_q, aw_idx_d;
	logic [15:0]  wdat_q, wdat_d;
	logic [3:0]   wstb_q, wstb_d;
	logic         bvalid_q, bvalid_d;
	logic [1:0]   bresp_q, bresp_d;
	logic         rvalid_q, rvalid_d;
	logic [31:0]  rdata_q, rdata_d;
	logic [1:0]   rresp_q, rresp_d;

	// Byte-enable merge of a 16-bit register under a keep mask
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nv,
		input logic [3:0] stb, input logic [15:0] keep);
		logic [15:0] r;
		r = old;
		if (stb[0]) begin
			r[7:0] = nv[7:0];
		end
		if (stb[1]) begin
			r[15:8] = nv[15:8];
		end
		return r & keep;
	endfunction

	function automatic logic [7:0] word_index(input logic [31:0] addr);
		return addr[9:2];
	endfunction

	function automatic logic is_cal(input logic [7:0] idx);
		return ((idx >= IDX_CAL_FIRST) && (idx <= IDX_CAL_LAST)) || (idx == IDX_CAL_EXTRA);
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		logic r;
		r = is_cal(idx);
		case (idx)
			IDX_BAL_LOW_THR, IDX_BAL_HIGH_THR, IDX_DIAGNOSTIC_RESULT_RESULT, IDX_DIAGNOSTIC_RESULT_CONFIG,
			IDX_CELL_TST_EN, IDX_ALU_ODD_1, IDX_ALU_ODD_2, IDX_ALU_EVEN_1,
			IDX_ALU_EVEN_2, IDX_CONTROL, IDX_STATUS: r = 1'b1;
			default: r = r;
		endcase
		return r;
	endfunction

	// Strict compare on the upper fourteen bits; the two low bits never matter
	function automatic logic bal_fail(input logic [13:0] v, input logic [15:0] lo, input logic [15:0] hi);
		logic below;
		logic above;
		below = v < lo[15:2];
		above = v > hi[15:2];
		return below || above;
	endfunction

	logic       wr_fire;
	logic [7:0] rd_idx;
	logic [15:0] rd_val;
	logic       bal_hit;

	// Write channel: address and data accepted independently, response after both
	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d  = w_held_q;
		aw_idx_d  = aw_idx_q;
		wdat_d    = wdat_q;
		wstb_d    = wstb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		wr_fire   = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			aw_idx_d  = word_index(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			wdat_d   = s_axi_wdata[15:0];
			wstb_d   = s_axi_wstrb;
		end
		// Commit waits for the last response to be taken: one write in flight
		if (aw_held_q && w_held_q && !bvalid_q) begin
			wr_fire   = 1'b1;
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = is_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// Register file writes
	always_comb begin
		low_thr_d  = low_thr_q;
		high_thr_d = high_thr_q;
		cfg_d      = cfg_q;
		cell_en_d  = cell_en_q;
		ctl_d      = ctl_q;
		for (int i = 0; i < 4; i++) begin
			alu_word_d[i] = alu_word_q[i];
		end
		if (wr_fire) begin
			case (aw_idx_q)
				IDX_BAL_LOW_THR:  low_thr_d  = merge(low_thr_q, wdat_q, wstb_q, MASK_THR14);
				IDX_BAL_HIGH_THR: high_thr_d = merge(high_thr_q, wdat_q, wstb_q, MASK_THR14);
				IDX_DIAGNOSTIC_RESULT_CONFIG:  cfg_d      = merge(cfg_q, wdat_q, wstb_q, MASK_DIAGNOSTIC_RESULT_CFG);
				IDX_CELL_TST_EN:  cell_en_d  = merge(cell_en_q, wdat_q, wstb_q, MASK_CELL_EN);
				IDX_ALU_ODD_1:    alu_word_d[0] = merge(alu_word_q[0], wdat_q, wstb_q, MASK_ALU_WORD);
				IDX_ALU_ODD_2:    alu_word_d[1] = merge(alu_word_q[1], wdat_q, wstb_q, MASK_ALU_WORD);
				IDX_ALU_EVEN_1:   alu_word_d[2] = merge(alu_word_q[2], wdat_q, wstb_q, MASK_ALU_WORD);
				IDX_ALU_EVEN_2:   alu_word_d[3] = merge(alu_word_q[3], wdat_q, wstb_q, MASK_ALU_WORD);
				IDX_CONTROL:      ctl_d      = merge(ctl_q, wdat_q, wstb_q, MASK_CONTROL);
				default: ; // Result and calibration ignore writes; a status write clears the alert
			endcase
		end
	end

	// Read channel; one-cycle answer after address is taken
	always_comb begin
		rd_idx = word_index(s_axi_araddr);
		rd_val = RST_ZERO;
		case (rd_idx)
			IDX_BAL_LOW_THR:  rd_val = low_thr_q;
			IDX_BAL_HIGH_THR: rd_val = high_thr_q;
			IDX_DIAGNOSTIC_RESULT_RESULT:  rd_val = diagnostic_result_q;
			IDX_DIAGNOSTIC_RESULT_CONFIG:  rd_val = cfg_q;
			IDX_CELL_TST_EN:  rd_val = cell_en_q;
			IDX_ALU_ODD_1:    rd_val = alu_word_q[0];
			IDX_ALU_ODD_2:    rd_val = alu_word_q[1];
			IDX_ALU_EVEN_1:   rd_val = alu_word_q[2];
			IDX_ALU_EVEN_2:   rd_val = alu_word_q[3];
			IDX_CONTROL:      rd_val = ctl_q;
			IDX_STATUS:       rd_val = {15'h0000, alert_q};
			default:          rd_val = is_cal(rd_idx) ? CAL_TRIM : RST_ZERO;
		endcase
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		// Unmapped index answers zero with an error code
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rdata_d  = {16'h0000, rd_val};
			rresp_d  = is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// Diagnostic result capture and balancing-switch comparison
	always_comb begin
		diagnostic_result_d  = diagnostic_result_q;
		alert_d = alert_q;
		bal_hit = conv_result.valid && conv_result.bal_test
			&& bal_fail(conv_result.value, low_thr_q, high_thr_q);
		if (conv_result.valid) begin
			diagnostic_result_d = {conv_result.value, 2'b00};
		end
		// Sticky until the status word is written
		if (wr_fire && (aw_idx_q == IDX_STATUS)) begin
			alert_d = 1'b0;
		end
		// Set after clear, so a failing result in the clear cycle is not lost
		if (bal_hit) begin
			alert_d = 1'b1;
		end
	end

	// ALU test injection sequence over conversions of a sample pair
	always_comb begin
		conv_d = conv_q;
		alu_d  = alu_q;
		if (conv_start) begin
			alu_d = adc_data;
			if (ctl_q[CTL_ALU_BIT]) begin
				case (conv_q)
					BMDG_CONV_ODD1:  alu_d = alu_word_q[0][11:0];
					BMDG_CONV_ODD2:  alu_d = alu_word_q[1][11:0];
					BMDG_CONV_EVEN1: alu_d = alu_word_q[2][11:0];
					BMDG_CONV_EVEN2: alu_d = alu_word_q[3][11:0];
					default:         alu_d = adc_data;
				endcase
			end
			// Second conversion keeps its slot until the sample ends
			case (conv_q)
				BMDG_CONV_ODD1:  conv_d = BMDG_CONV_ODD2;
				BMDG_CONV_EVEN1: conv_d = BMDG_CONV_EVEN2;
				default:         conv_d = conv_q;
			endcase
		end
		if (conv_sample_end) begin
			// Even samples only exist with oversampling on
			case (conv_q)
				BMDG_CONV_ODD1, BMDG_CONV_ODD2:
					conv_d = ctl_q[CTL_OVS_BIT] ? BMDG_CONV_EVEN1 : BMDG_CONV_ODD1;
				BMDG_CONV_EVEN1, BMDG_CONV_EVEN2: conv_d = BMDG_CONV_ODD1;
				default: conv_d = BMDG_CONV_ODD1;
			endcase
		end
	end

	// Analog control decode from configuration fields
	// Registered one cycle late so the switches see clean levels
	always_comb begin
		ana_d.level     = cfg_q[CFG_LEVEL_LSB +: 4];
		ana_d.source    = cfg_q[CFG_DIR_BIT];
		ana_d.aux_en    = cfg_q[CFG_AUX_LSB +: 2];
		ana_d.cell_en   = cell_en_q[12:0];
		ana_d.mux_en    = cfg_q[CFG_MUXEN_BIT];
		ana_d.mux_even  = cfg_q[CFG_MUXEN_BIT] && (cfg_q[CFG_PAIR_BIT] || !cfg_q[CFG_BUS_BIT]);
		ana_d.mux_odd   = cfg_q[CFG_MUXEN_BIT] && (cfg_q[CFG_PAIR_BIT] || cfg_q[CFG_BUS_BIT]);
		ana_d.alt_input = cfg_q[CFG_ALT_BIT];
		ana_d.selector  = bmdg_sel_t'(cfg_q[2:0]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			low_thr_q  <= RST_ZERO;
			high_thr_q <= RST_ZERO;
			diagnostic_result_q     <= RST_ZERO;
			cfg_q      <= RST_ZERO;
			cell_en_q  <= RST_ZERO;
			ctl_q      <= RST_ZERO;
			for (int i = 0; i < 4; i++) begin
				alu_word_q[i] <= RST_ALU_ODD;
			end
			alert_q    <= 1'b0;
			conv_q     <= BMDG_CONV_ODD1;
			alu_q      <= 12'h000;
			ana_q      <= '0;
			aw_held_q  <= 1'b0;
			w_held_q   <= 1'b0;
			aw_idx_q   <= 8'h00;
			wdat_q     <= RST_ZERO;
			wstb_q     <= 4'h0;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			rvalid_q   <= 1'b0;
			rdata_q    <= 32'h00000000;
			rresp_q    <= RESP_OKAY;
		end else begin
			low_thr_q  <= low_thr_d;
			high_thr_q <= high_thr_d;
			diagnostic_result_q     <= diagnostic_result_d;
			cfg_q      <= cfg_d;
			cell_en_q  <= cell_en_d;
			ctl_q      <= ctl_d;
			for (int i = 0; i < 4; i++) begin
				alu_word_q[i] <= alu_word_d[i];
			end
			alert_q    <= alert_d;
			conv_q     <= conv_d;
			alu_q      <= alu_d;
			ana_q      <= ana_d;
			aw_held_q  <= aw_held_d;
			w_held_q   <= w_held_d;
			aw_idx_q   <= aw_idx_d;
			wdat_q     <= wdat_d;
			wstb_q     <= wstb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rdata_q    <= rdata_d;
			rresp_q    <= rresp_d;
		end
	end

	// Ready terms are flop outputs: free while the channel holds nothing,
	// dropped right after a take so no second item slips in
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic arready_q, arready_d;

	always_comb begin
		awready_d = !aw_held_d && !(s_axi_awvalid && awready_q);
		wready_d  = !w_held_d && !(s_axi_wvalid && wready_q);
		arready_d = !rvalid_d && !(s_axi_arvalid && arready_q);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_arready = arready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign analog_ctl    = ana_q;
	assign alu_data      = alu_q;
	assign bal_alert     = alert_q;

endmodule // bmdiag_top

// ===== testbench/bmdiag_sva.sv
// Purpose: Port-level checks for the diagnostic block
// Assumes: Bound to bmdiag_top, one clock domain
// Notes:   Thresholds are internal, so alert checks tie to result pulses
`timescale 1ns/10ps
module bmdiag_sva
	import bmdiag_pkg::*;
(
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic         s_axi_awvalid,
	input wire logic         s_axi_awready,
	input wire logic         s_axi_bvalid,
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic         s_axi_rvalid,
	input wire logic [31:0]  s_axi_rdata,
	input wire bmdg_result_t conv_result,
	input wire logic         conv_start,
	input wire bmdg_analog_t analog_ctl,
	input wire logic [11:0]  alu_data,
	input wire logic         bal_alert
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	alert_cause_a: assert property ($rose(bal_alert) |-> $past(conv_result.valid && conv_result.bal_test))
		else $error("alert rose without a balancing result");
	alert_sticky_a: assert property ($fell(bal_alert) |-> $rose(s_axi_bvalid))
		else $error("alert dropped without a write");
	alu_hold_a: assert property (!conv_start |=> $stable(alu_data))
		else $error("alu data moved without a conversion");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	ctl_write_a: assert property ($changed(analog_ctl) |-> $past(s_axi_bvalid))
		else $error("analog controls moved without a write");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
	mux_gate_a: assert property (analog_ctl.mux_even || analog_ctl.mux_odd |-> analog_ctl.mux_en)
		else $error("mux output driven while disabled");
endmodule // bmdiag_sva

// ===== testbench/bmdiag_conv_model.sv
// Purpose: Converter side model feeding conversions and results
// Assumes: Driven one cycle pulses, changes right after the rising edge
// Notes:   Released data is inverted so stale values cannot pass
`timescale 1ns/10ps
module bmdiag_conv_model
	import bmdiag_pkg::*;
(
	input  wire logic   aclk,
	output bmdg_result_t conv_result,
	output logic         conv_start,
	output logic         conv_sample_end,
	output logic [11:0]  adc_data
);
	initial begin
		conv_result = '0;
		conv_start = 1'b0;
		conv_sample_end = 1'b0;
		adc_data = 12'h000;
	end
	task automatic conv(input logic [11:0] d);
		@(posedge aclk);
		conv_start <= 1'b1;
		adc_data <= d;
		@(posedge aclk);
		conv_start <= 1'b0;
		adc_data <= ~d;
	endtask
	task automatic result(input logic [13:0] v, input logic b);
		@(posedge aclk);
		conv_result <= {1'b1, v, b};
		@(posedge aclk);
		conv_result <= {1'b0, ~v, ~b};
	endtask
	task automatic sample_end;
		@(posedge aclk);
		conv_sample_end <= 1'b1;
		@(posedge aclk);
		conv_sample_end <= 1'b0;
	endtask
endmodule // bmdiag_conv_model

// ===== testbench/bmdiag_top_bench.sv
// Purpose: Register and converter scenarios for the diagnostic block
// Assumes: AXI4-Lite master tasks, byte address is index times four
// Notes:   Trim value is arbitrary
`timescale 1ns/10ps
module bmdiag_top_bench;
	import bmdiag_pkg::*;
	localparam logic [15:0] TRIM = 16'h5a3c;
	logic              aclk;
	logic              aresetn;
	logic [31:0]       awa;
	logic              awv;
	logic              awr;
	logic [31:0]       wd;
	logic [3:0]        ws;
	logic              wv;
	logic              wrd;
	logic [1:0]        bresp;
	logic              bv;
	logic              brd;
	logic [31:0]       ara;
	logic              arv;
	logic              arr;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              rv;
	logic              rrd;
	bmdg_result_t      cres;
	logic              cst;
	logic              cend;
	logic [11:0]       adc;
	bmdg_analog_t      analog_ctl;
	logic [11:0]       alu_data;
	logic              bal_alert;
	logic [2:0]        s;
	bmdg_analog_t      ea;
	int                checks = 0;
	int                n_mismatch = 0;
	logic [7:0]        ix[8] = '{8'h4c, 8'h4d, 8'h51, 8'h52, 8'h57, 8'h58, 8'h59, 8'h5a};
	logic [15:0]       mk[8] = '{16'hfffc, 16'hfffc, 16'hfbdf, 16'h1fff, 16'h0fff, 16'h0fff, 16'h0fff, 16'h0fff};
	logic [7:0]        cx[3] = '{8'hc0, 8'hca, 8'hcf};
	logic [13:0]       tv[5] = '{14'h0400, 14'h2000, 14'h03ff, 14'h2001, 14'h0100};
	logic              tb[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	logic              ta[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

	bmdiag_top #(.CAL_TRIM(TRIM)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
		.conv_result(cres), .conv_start(cst), .conv_sample_end(cend), .adc_data(adc),
		.analog_ctl(analog_ctl), .alu_data(alu_data), .bal_alert(bal_alert));
	bmdiag_conv_model cm (.aclk(aclk), .conv_result(cres), .conv_start(cst), .conv_sample_end(cend),
		.adc_data(adc));

	task automatic conclude;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 64) begin
			n_mismatch++;
			conclude();
		end
	endtask
	// Response 2'b11 means the response code is not compared
	task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awa <= {22'h0, i, 2'b00};
		wd <= {16'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		brd <= 1'b1;
		for (n = 0; n < 64 && !bv; n++) begin
			@(posedge aclk);
			if (awr)
				awv <= 1'b0;
			if (wrd)
				wv <= 1'b0;
		end
		brd <= 1'b0;
		tmo(n);
		if (er != 2'b11)
			chk(bresp, er);
	endtask
	task automatic rd(input logic [7:0] i, input logic [15:0] e, input logic [1:0] er);
		int n;
		@(posedge aclk);
		ara <= {22'h0, i, 2'b00};
		arv <= 1'b1;
		rrd <= 1'b1;
		for (n = 0; n < 64 && !rv; n++) begin
			@(posedge aclk);
			if (arr)
				arv <= 1'b0;
		end
		rrd <= 1'b0;
		tmo(n);
		chk({rresp, rdata}, {er, 16'h0, e});
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		{aresetn, awv, wv, brd, arv, rrd, awa, wd, ara} = '0;
		ws = 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int j = 0; j < 8; j++) begin
			rd(ix[j], 16'h0000, RESP_OKAY);
			wr(ix[j], 16'hffff, RESP_OKAY);
			rd(ix[j], mk[j], RESP_OKAY);
		end
		wr(IDX_DIAGNOSTIC_RESULT_RESULT, 16'hffff, RESP_OKAY);
		rd(IDX_DIAGNOSTIC_RESULT_RESULT, 16'h0000, RESP_OKAY);
		for (int j = 0; j < 3; j++) begin
			wr(cx[j], 16'h0000, RESP_OKAY);
			rd(cx[j], TRIM, RESP_OKAY);
		end
		wr(8'h53, 16'h1234, RESP_SLVERR);
		rd(8'h53, 16'h0000, RESP_SLVERR);
		wr(IDX_CELL_TST_EN, 16'h1555, RESP_OKAY);
		for (int k = 0; k < 8; k++) begin
			s = k[2:0];
			wr(IDX_DIAGNOSTIC_RESULT_CONFIG, {4'hf - 4'(k), s[0], 1'b0, s[1:0], s[0], s[1], 1'b0, s[2], s[0], s}, RESP_OKAY);
			@(posedge aclk);
			// Even output: enabled and (pair or bus 0); odd output: enabled and (pair or bus 1)
			ea = {4'hf - 4'(k), s[0], s[1:0], 13'h1555, s[2], s[2] & (s[1] | !s[0]), s[2] & (s[1] | s[0]), s[0], s};
			chk(analog_ctl, ea);
		end
		for (int k = 0; k < 4; k++)
			wr(IDX_ALU_ODD_1 + 8'(k), 16'h1111 * 16'(k + 1), RESP_OKAY);
		wr(IDX_CONTROL, 16'h0003, RESP_OKAY);
		for (int k = 0; k < 5; k++) begin
			cm.conv(12'h0a5);
			@(posedge aclk);
			chk(alu_data, 12'h111 * 12'(k % 4 + 1));
			if (k % 2 == 1)
				cm.sample_end();
		end
		wr(IDX_CONTROL, 16'h0000, RESP_OKAY);
		cm.conv(12'h7e5);
		@(posedge aclk);
		chk(alu_data, 12'h7e5);
		// Thresholds go in before any balancing result arrives
		wr(IDX_BAL_LOW_THR, 16'h1003, RESP_OKAY);
		wr(IDX_BAL_HIGH_THR, 16'h8002, RESP_OKAY);
		for (int k = 0; k < 5; k++) begin
			cm.result(tv[k], tb[k]);
			@(posedge aclk);
			chk(bal_alert, ta[k]);
			rd(IDX_STATUS, {15'h0, ta[k]}, RESP_OKAY);
			wr(IDX_STATUS, 16'h0000, RESP_OKAY);
		end
		rd(IDX_DIAGNOSTIC_RESULT_RESULT, 16'h0400, RESP_OKAY);
		// Low byte lane only: the upper byte keeps its old value
		ws <= 4'h1;
		wr(IDX_CELL_TST_EN, 16'h0aaa, RESP_OKAY);
		rd(IDX_CELL_TST_EN, 16'h15aa, RESP_OKAY);
		conclude();
	end
endmodule // bmdiag_top_bench

bind bmdiag_top bmdiag_sva chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .conv_result, .conv_start, .analog_ctl, .alu_data, .bal_alert);
